// >>> tb/testbench.sv
/*
  Self-checking bench of the tri-state memory bus path: APB timing words,
  both memory channels, reset behaviour of the pads.
  Assumes tmb_top and the memory model; one 100 MHz clock.
*/
`timescale 1ns/10ps
`default_nettype none
`include "tmb_defs.svh"
module testbench;
  logic sys_clk_i = 0, rst_i = 1;
  logic psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, mm1_rdata, pad_data_o, pad_din, mem_d;
  logic pready, pslverr, mm0_rdvalid, mm0_wait, mm1_rdvalid, mm1_wait;
  logic [21:0] mm0_addr = 0, pad_addr, exp_a [2];
  logic [19:0] mm1_addr = 0;
  logic [15:0] mm0_wdata = 0, mm0_rdata;
  logic [31:0] mm1_wdata = 0, q, d, tim [2];
  logic mm0_read = 0, mm0_write = 0, mm1_read = 0, mm1_write = 0;
  logic pad_rd_n, pad_wr_n, pad_ctl_oe, pad_data_oe, err;
  logic [1:0] pad_cs_n;
  int failures = 0, tests_run = 0, lat;
  assign pad_din = pad_data_oe ? pad_data_o : mem_d;
  tmb_top uut (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
    .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr), .mm0_addr_i(mm0_addr), .mm0_read_i(mm0_read),
    .mm0_write_i(mm0_write), .mm0_wdata_i(mm0_wdata),
    .mm0_rdata_o(mm0_rdata), .mm0_rdvalid_o(mm0_rdvalid),
    .mm0_wait_o(mm0_wait), .mm1_addr_i(mm1_addr), .mm1_read_i(mm1_read),
    .mm1_write_i(mm1_write), .mm1_wdata_i(mm1_wdata),
    .mm1_rdata_o(mm1_rdata), .mm1_rdvalid_o(mm1_rdvalid),
    .mm1_wait_o(mm1_wait), .pad_addr_o(pad_addr), .pad_rd_n_o(pad_rd_n),
    .pad_wr_n_o(pad_wr_n), .pad_cs_n_o(pad_cs_n), .pad_ctl_oe_o(pad_ctl_oe),
    .pad_data_o(pad_data_o), .pad_data_oe_o(pad_data_oe),
    .pad_data_i(pad_din));
  tmb_mem_model mem (.clk_i(sys_clk_i), .addr_i(pad_addr),
    .rd_n_i(pad_rd_n), .wr_n_i(pad_wr_n), .cs_n_i(pad_cs_n),
    .oe_i(pad_ctl_oe), .data_i(pad_data_o), .data_o(mem_d));
  initial begin
    forever #5 sys_clk_i = ~sys_clk_i;
  end
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (e !== g) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic end_sim();
    $display("compares %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic apb(input bit wr, input logic [11:0] a, input logic [31:0] wd);
    @(posedge sys_clk_i);
    psel <= 1; pwrite <= wr; paddr <= a; pwdata <= wd; penable <= 0;
    @(posedge sys_clk_i);
    penable <= 1;
    do @(posedge sys_clk_i); while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel <= 0; penable <= 0;
  endtask
  task automatic mm(input int ch, input bit wr, input logic [21:0] a,
                    input logic [31:0] wd, output logic [31:0] rd, output int n);
    @(posedge sys_clk_i);
    exp_a[ch] <= (ch == 0) ? a : {2'b00, a[19:0]};
    if (ch == 0) begin
      mm0_addr <= a; mm0_wdata <= wd[15:0]; mm0_read <= !wr; mm0_write <= wr;
    end else begin
      mm1_addr <= a[19:0]; mm1_wdata <= wd; mm1_read <= !wr; mm1_write <= wr;
    end
    n = 0;
    do begin
      @(posedge sys_clk_i);
      n++;
    end while ((ch == 0 ? mm0_wait : mm1_wait) !== 1'b0);
    if (ch == 0) begin mm0_read <= 0; mm0_write <= 0; end
    else begin mm1_read <= 0; mm1_write <= 0; end
    if (!wr) begin
      repeat (3) @(posedge sys_clk_i);
      chk("rdvalid", 1, ch == 0 ? mm0_rdvalid : mm1_rdvalid);
      rd = (ch == 0) ? {16'h0000, mm0_rdata} : mm1_rdata;
    end
  endtask
  task automatic do_reset();
    rst_i <= 1;
    repeat (10) @(posedge sys_clk_i);
    chk("rst_ctl_oe", 0, pad_ctl_oe);
    chk("rst_data_oe", 0, pad_data_oe);
    rst_i <= 0;
    repeat (2) @(posedge sys_clk_i);
    chk("first_ctl_oe", 1, pad_ctl_oe);
  endtask
  // pad watchers: owner address, zero fill and exclusive selects
  always @(posedge sys_clk_i) begin
    if (!rst_i && pad_ctl_oe && (!pad_rd_n || !pad_wr_n)) begin
      chk("cs_excl", 1, pad_cs_n != 2'b00);
      if (pad_cs_n == 2'b10) chk("addr0", exp_a[0], pad_addr);
      if (pad_cs_n == 2'b01) chk("addr1", exp_a[1], pad_addr);
      if (pad_cs_n == 2'b10 && !pad_wr_n && pad_data_oe)
        chk("data_hi", 0, pad_data_o[31:16]);
    end
  end
  initial begin
    repeat (20000) @(posedge sys_clk_i);
    failures++;
    end_sim();
  end
  initial begin
    void'($urandom(32'h660D5F34));
    do_reset();
    apb(0, `TMB_OFF_TIM0, 0); chk("tim0_rst", 32'h00001233, q);
    apb(0, `TMB_OFF_TIM1, 0); chk("tim1_rst", 32'h00000111, q);
    apb(0, `TMB_OFF_STAT, 0); chk("stat_oe", 2, q & 32'h3);
    apb(1, 12'h00C, 32'hFFFFFFFF); chk("unmapped", 1, err);
    apb(0, 12'h00C, 0); chk("unmapped_rd", 0, q);
    $display("test reset_regs done");
    for (int c = 0; c < 2; c++) begin
      tim[c] = ($urandom & 32'h3333) + 32'h1111;
      apb(1, c ? `TMB_OFF_TIM1 : `TMB_OFF_TIM0, tim[c]);
      apb(0, c ? `TMB_OFF_TIM1 : `TMB_OFF_TIM0, 0);
      chk("tim_rw", tim[c], q);
    end
    $display("test timing_words done");
    for (int i = 0; i < 8; i++) begin
      int c;
      logic [21:0] a;
      c = i % 2;
      a = $urandom;
      d = $urandom;
      if (i == 7) a = 22'h3FFFFF;
      mm(c, 1, a, d, q, lat);
      mm(c, 0, a, 0, q, lat);
      chk("rdata", c ? d : d & 32'hFFFF, q);
      chk("wait_min", 1, lat >= tim[c][3:0] + 3);
    end
    $display("test single_channel done");
    fork
      mm(0, 1, 22'h000011, 32'h0000A5C3, q, lat);
      mm(1, 1, 22'h000022, 32'h5A3CC3A5, d, lat);
    join
    fork
      begin mm(0, 0, 22'h000011, 0, q, lat); chk("rr0", 32'hA5C3, q); end
      begin mm(1, 0, 22'h000022, 0, d, lat); chk("rr1", 32'h5A3CC3A5, d); end
    join
    $display("test contention done");
    do_reset();
    apb(0, `TMB_OFF_TIM0, 0); chk("tim0_rst2", 32'h00001233, q);
    $display("test second_reset done");
    end_sim();
  end
endmodule
`default_nettype wire

// >>> tb/tmb_mem_model.sv
/*
  Behavioural model of the off-chip memories behind the pads: one array
  with one half per chip select, written and read through the registered strobes.
  Assumes the pads share the bench clock and the bench resolves the data.
*/
`timescale 1ns/10ps
`default_nettype none
module tmb_mem_model (
  input wire logic clk_i,
  input wire logic [21:0] addr_i,
  input wire logic rd_n_i,
  input wire logic wr_n_i,
  input wire logic [1:0] cs_n_i,
  input wire logic oe_i,
  input wire logic [31:0] data_i,
  output logic [31:0] data_o
);
  logic [31:0] mem [0:511];
  logic [31:0] last_reg;
  wire [8:0] idx = {cs_n_i[0], addr_i[7:0]};
  wire sel = oe_i && (cs_n_i != 2'b11);
  wire rd_on = sel && !rd_n_i;
  // released bus shows the inverse of the last value
  assign data_o = rd_on ? mem[idx] : ~last_reg;
  always_ff @(posedge clk_i) begin
    if (sel && !wr_n_i) begin
      mem[idx] <= data_i;
    end
    last_reg <= data_o;
  end
endmodule
`default_nettype wire

// >>> verilog/tmb_ctrl.sv
/*
  One generic tri-state controller: memory-mapped slave in, conduit
  master out, timing taken from a 16-bit timing word.
  Assumes the grant comes from the pin sharer in the same clock domain.
*/
`timescale 1ns/10ps
`default_nettype none
`include "tmb_defs.svh"
module tmb_ctrl #(
  parameter int ADDR_W = 22,
  parameter int DATA_W = 16
) (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic [`TMB_TIM_W-1:0] timing_i,
  input wire logic [ADDR_W-1:0] mm_addr_i,
  input wire logic mm_read_i,
  input wire logic mm_write_i,
  input wire logic [DATA_W-1:0] mm_wdata_i,
  output logic [DATA_W-1:0] mm_rdata_o,
  output logic mm_rdvalid_o,
  output logic mm_wait_o,
  output logic tcm_req_o,
  input wire logic tcm_grant_i,
  output logic [ADDR_W-1:0] tcm_addr_o,
  output logic [DATA_W-1:0] tcm_dout_o,
  output logic tcm_doe_o,
  output logic tcm_rd_n_o,
  output logic tcm_wr_n_o,
  output logic tcm_cs_n_o,
  input wire logic [DATA_W-1:0] tcm_din_i
);
  import tmb_pkg::*;

  tmb_ctl_state_t state_reg, state_next;
  logic [`TMB_CNT_W-1:0] cnt_reg;
  logic is_rd_reg;
  logic [ADDR_W-1:0] addr_reg;
  logic [DATA_W-1:0] wdata_reg;
  logic [DATA_W-1:0] rdata_reg;
  logic rdvalid_reg;
  logic wait_reg;
  logic req_reg;

  wire [`TMB_CNT_W-1:0] rd_wait = {1'b0, timing_i[`TMB_RDW_LSB +: 4]};
  wire [`TMB_CNT_W-1:0] wr_wait = {1'b0, timing_i[`TMB_WRW_LSB +: 4]};
  wire [`TMB_CNT_W-1:0] turn = {1'b0, timing_i[`TMB_TURN_LSB +: 4]};
  wire [`TMB_CNT_W-1:0] hold = {1'b0, timing_i[`TMB_HOLD_LSB +: 4]};
  wire [`TMB_CNT_W-1:0] wait_cnt = is_rd_reg ? rd_wait : wr_wait;
  // read latency includes both bridge stages
  wire [`TMB_CNT_W-1:0] rd_gap = (turn > `TMB_BRIDGE_LAT) ? turn :
                                 `TMB_BRIDGE_LAT;
  wire [`TMB_CNT_W-1:0] wr_gap = (turn > hold) ? turn : hold;
  wire [`TMB_CNT_W-1:0] gap = is_rd_reg ? rd_gap : wr_gap;
  wire in_idle = (state_reg == TMB_IDLE);
  wire in_req = (state_reg == TMB_REQ);
  wire in_act = (state_reg == TMB_ACT);
  wire in_turn = (state_reg == TMB_TURN);
  wire new_cmd = in_idle && (mm_read_i || mm_write_i);
  wire accept = in_act && (cnt_reg == wait_cnt);
  wire turn_done = in_turn && (cnt_reg >= gap);
  wire [`TMB_CNT_W-1:0] cnt_inc = cnt_reg + 5'h01;
  // the cycle before accept, so wait-request can be a flop
  wire accept_pre = (in_req && tcm_grant_i && wait_cnt == 5'h00) ||
                    (in_act && cnt_inc == wait_cnt);
  wire hold_win = in_turn && !is_rd_reg && (cnt_reg <= hold);
  wire rd_capture = in_turn && is_rd_reg && (cnt_reg == `TMB_BRIDGE_LAT);

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      TMB_IDLE: if (new_cmd) state_next = TMB_REQ;
      TMB_REQ: if (tcm_grant_i) state_next = TMB_ACT;
      TMB_ACT: if (accept) state_next = TMB_TURN;
      TMB_TURN: if (turn_done) state_next = TMB_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_reg <= TMB_IDLE;
      cnt_reg <= 5'h00;
      req_reg <= 1'b0;
      wait_reg <= 1'b1;
    end else begin
      state_reg <= state_next;
      wait_reg <= !accept_pre;
      if (new_cmd) begin
        req_reg <= 1'b1;
      end else if (turn_done) begin
        req_reg <= 1'b0;
      end
      if (in_req) begin
        cnt_reg <= 5'h00;
      end else if (accept) begin
        cnt_reg <= 5'h01;
      end else if (in_act || in_turn) begin
        cnt_reg <= cnt_inc;
      end
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      is_rd_reg <= 1'b0;
      addr_reg <= '0;
      wdata_reg <= '0;
      rdata_reg <= '0;
      rdvalid_reg <= 1'b0;
    end else begin
      if (new_cmd) begin
        is_rd_reg <= mm_read_i;
        addr_reg <= mm_addr_i;
        wdata_reg <= mm_wdata_i;
      end
      rdvalid_reg <= rd_capture;
      if (rd_capture) begin
        rdata_reg <= tcm_din_i;
      end
    end
  end

  assign mm_rdata_o = rdata_reg;
  assign mm_rdvalid_o = rdvalid_reg;
  assign mm_wait_o = wait_reg;
  assign tcm_req_o = req_reg;
  assign tcm_addr_o = addr_reg;
  assign tcm_dout_o = wdata_reg;
  assign tcm_doe_o = !is_rd_reg && (in_act || hold_win);
  assign tcm_rd_n_o = !(in_act && is_rd_reg);
  assign tcm_wr_n_o = !(in_act && !is_rd_reg);
  assign tcm_cs_n_o = !(in_act || hold_win);

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);

  sequence s_accept_read;
    accept && is_rd_reg;
  endsequence

  AST_WAIT_NEEDS_GRANT: assert property (
    !mm_wait_o |-> tcm_grant_i && accept)
    else $error("wait-request low without grant or elapsed wait");
  AST_GAP_FROM_ACCEPT: assert property (
    $fell(tcm_req_o) |-> $past(cnt_reg) ==
      (($past(gap) > 5'h01) ? $past(gap) : 5'h01))
    else $error("request released before the turnaround gap");
  AST_READ_GAP_MAX: assert property (
    turn_done && is_rd_reg |-> cnt_reg >= `TMB_BRIDGE_LAT && cnt_reg >= turn)
    else $error("read gap shorter than turnaround or latency");
  AST_READ_DATA_LAT: assert property (
    s_accept_read |-> !mm_rdvalid_o [*3] ##1 mm_rdvalid_o)
    else $error("read data not returned three cycles after accept");
endmodule
`default_nettype wire

// >>> verilog/tmb_defs.svh
/*
  Constants of the tri-state memory bus path: register offsets, timing
  fields, reset values, widths and the bridge latency.
  Assumes inclusion by bare name from the design files and the bench.
*/
`ifndef TMB_DEFS_SVH
`define TMB_DEFS_SVH

`define TMB_APB_AW 12
`define TMB_OFF_TIM0 12'h000
`define TMB_OFF_TIM1 12'h004
`define TMB_OFF_STAT 12'h008

`define TMB_TIM_W 16
`define TMB_FLD_W 4
`define TMB_RDW_LSB 0
`define TMB_WRW_LSB 4
`define TMB_TURN_LSB 8
`define TMB_HOLD_LSB 12
`define TMB_TIM0_RST 16'h1233
`define TMB_TIM1_RST 16'h0111

`define TMB_CNT_W 5
`define TMB_BRIDGE_LAT 5'h02

`define TMB_A0_W 22
`define TMB_D0_W 16
`define TMB_A1_W 20
`define TMB_D1_W 32
`define TMB_BUS_A_W 22
`define TMB_BUS_D_W 32

`endif

// >>> verilog/tmb_pkg.sv
/*
  Types shared by the tri-state memory bus path.
  Assumes tmb_defs.svh on the include path.
*/
package tmb_pkg;
  typedef enum logic [3:0] {
    TMB_IDLE = 4'b0001,
    TMB_REQ  = 4'b0010,
    TMB_ACT  = 4'b0100,
    TMB_TURN = 4'b1000
  } tmb_ctl_state_t;
endpackage

// >>> verilog/tmb_top.sv
/*
  Tri-state memory bus path: two generic controllers, a round-robin pin
  sharer, a registering conduit bridge with pad enables, and an APB slave
  holding the controllers' timing words and a status word.
  Assumes one clock for all parts and an external pad model that resolves
  the data pins from the output enable.
*/
// The address map and the APB interface to the registers are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
`include "tmb_defs.svh"
module tmb_top (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [`TMB_APB_AW-1:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic [`TMB_A0_W-1:0] mm0_addr_i,
  input wire logic mm0_read_i,
  input wire logic mm0_write_i,
  input wire logic [`TMB_D0_W-1:0] mm0_wdata_i,
  output logic [`TMB_D0_W-1:0] mm0_rdata_o,
  output logic mm0_rdvalid_o,
  output logic mm0_wait_o,
  input wire logic [`TMB_A1_W-1:0] mm1_addr_i,
  input wire logic mm1_read_i,
  input wire logic mm1_write_i,
  input wire logic [`TMB_D1_W-1:0] mm1_wdata_i,
  output logic [`TMB_D1_W-1:0] mm1_rdata_o,
  output logic mm1_rdvalid_o,
  output logic mm1_wait_o,
  output logic [`TMB_BUS_A_W-1:0] pad_addr_o,
  output logic pad_rd_n_o,
  output logic pad_wr_n_o,
  output logic [1:0] pad_cs_n_o,
  output logic pad_ctl_oe_o,
  output logic [`TMB_BUS_D_W-1:0] pad_data_o,
  output logic pad_data_oe_o,
  input wire logic [`TMB_BUS_D_W-1:0] pad_data_i
);
  import tmb_pkg::*;

  localparam int AW = `TMB_BUS_A_W;
  localparam int DW = `TMB_BUS_D_W;

  // register file
  logic [`TMB_TIM_W-1:0] tim0_reg;
  logic [`TMB_TIM_W-1:0] tim1_reg;
  logic [31:0] prdata_reg;
  logic pready_reg;
  logic pslverr_reg;

  // controller conduit sides
  logic c0_req, c0_doe, c0_rd_n, c0_wr_n, c0_cs_n;
  logic c1_req, c1_doe, c1_rd_n, c1_wr_n, c1_cs_n;
  logic [`TMB_A0_W-1:0] c0_addr;
  logic [`TMB_A1_W-1:0] c1_addr;
  logic [`TMB_D0_W-1:0] c0_dout;
  logic [`TMB_D1_W-1:0] c1_dout;

  // sharer state
  logic [1:0] gnt_reg;
  logic ptr_reg;

  // bridge registers
  logic [AW-1:0] br_addr_reg;
  logic [DW-1:0] br_dout_reg;
  logic [DW-1:0] br_din_reg;
  logic br_doe_reg;
  logic br_rd_n_reg;
  logic br_wr_n_reg;
  logic [1:0] br_cs_n_reg;
  logic br_oe_reg;

  // ---------------- APB slave ----------------
  wire apb_access = psel_i && penable_i;
  wire apb_done = apb_access && pready_reg;
  wire hit_tim0 = (paddr_i == `TMB_OFF_TIM0);
  wire hit_tim1 = (paddr_i == `TMB_OFF_TIM1);
  wire hit_stat = (paddr_i == `TMB_OFF_STAT);
  wire hit_any = hit_tim0 || hit_tim1 || hit_stat;
  wire [31:0] status_word = {25'h0, ptr_reg, c1_req, c0_req,
                             gnt_reg, br_oe_reg, 1'b0};
  wire [31:0] rd_mux = hit_tim0 ? {16'h0000, tim0_reg} :
                       hit_tim1 ? {16'h0000, tim1_reg} :
                       hit_stat ? status_word : 32'h00000000;

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= 32'h00000000;
    end else begin
      // one wait state: ready rises in the second access cycle
      pready_reg <= apb_access && !pready_reg;
      if (apb_access && !pready_reg) begin
        pslverr_reg <= !hit_any;
        prdata_reg <= pwrite_i ? 32'h00000000 : rd_mux;
      end else begin
        pslverr_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      tim0_reg <= `TMB_TIM0_RST;
      tim1_reg <= `TMB_TIM1_RST;
    end else if (apb_done && pwrite_i) begin
      if (hit_tim0) begin
        tim0_reg <= pwdata_i[`TMB_TIM_W-1:0];
      end
      if (hit_tim1) begin
        tim1_reg <= pwdata_i[`TMB_TIM_W-1:0];
      end
    end
  end

  assign prdata_o = prdata_reg;
  assign pready_o = pready_reg;
  assign pslverr_o = pslverr_reg;

  // ---------------- controllers ----------------
  tmb_ctrl #(.ADDR_W(`TMB_A0_W), .DATA_W(`TMB_D0_W)) u_ctrl0 (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .timing_i(tim0_reg),
    .mm_addr_i(mm0_addr_i),
    .mm_read_i(mm0_read_i),
    .mm_write_i(mm0_write_i),
    .mm_wdata_i(mm0_wdata_i),
    .mm_rdata_o(mm0_rdata_o),
    .mm_rdvalid_o(mm0_rdvalid_o),
    .mm_wait_o(mm0_wait_o),
    .tcm_req_o(c0_req),
    .tcm_grant_i(gnt_reg[0]),
    .tcm_addr_o(c0_addr),
    .tcm_dout_o(c0_dout),
    .tcm_doe_o(c0_doe),
    .tcm_rd_n_o(c0_rd_n),
    .tcm_wr_n_o(c0_wr_n),
    .tcm_cs_n_o(c0_cs_n),
    .tcm_din_i(br_din_reg[`TMB_D0_W-1:0])
  );

  tmb_ctrl #(.ADDR_W(`TMB_A1_W), .DATA_W(`TMB_D1_W)) u_ctrl1 (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .timing_i(tim1_reg),
    .mm_addr_i(mm1_addr_i),
    .mm_read_i(mm1_read_i),
    .mm_write_i(mm1_write_i),
    .mm_wdata_i(mm1_wdata_i),
    .mm_rdata_o(mm1_rdata_o),
    .mm_rdvalid_o(mm1_rdvalid_o),
    .mm_wait_o(mm1_wait_o),
    .tcm_req_o(c1_req),
    .tcm_grant_i(gnt_reg[1]),
    .tcm_addr_o(c1_addr),
    .tcm_dout_o(c1_dout),
    .tcm_doe_o(c1_doe),
    .tcm_rd_n_o(c1_rd_n),
    .tcm_wr_n_o(c1_wr_n),
    .tcm_cs_n_o(c1_cs_n),
    .tcm_din_i(br_din_reg[`TMB_D1_W-1:0])
  );

  // ---------------- pin sharer ----------------
  wire [1:0] req = {c1_req, c0_req};
  // owner dropped its request: hold and turnaround are over
  wire owner_done = |(gnt_reg & ~req);
  wire [1:0] pick_fav = ptr_reg ? 2'b10 : 2'b01;
  wire [1:0] pick_alt = ptr_reg ? 2'b01 : 2'b10;
  wire [1:0] pick = |(req & pick_fav) ? pick_fav :
                    |(req & pick_alt) ? pick_alt : 2'b00;
  wire [1:0] gnt_next = owner_done ? 2'b00 :
                        (gnt_reg == 2'b00) ? pick : gnt_reg;

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      gnt_reg <= 2'b00;
      ptr_reg <= 1'b0;
    end else begin
      gnt_reg <= gnt_next;
      if (owner_done) begin
        ptr_reg <= gnt_reg[0];
      end
    end
  end

  // address, data, data enable and strobes share one name each
  wire [AW-1:0] c0_addr_al = c0_addr;
  wire [AW-1:0] c1_addr_al = {{(AW-`TMB_A1_W){1'b0}}, c1_addr};
  wire [DW-1:0] c0_dout_al = {{(DW-`TMB_D0_W){1'b0}}, c0_dout};
  wire [DW-1:0] c1_dout_al = c1_dout;
  wire [AW-1:0] sh_addr = gnt_reg[0] ? c0_addr_al :
                          gnt_reg[1] ? c1_addr_al : '0;
  wire [DW-1:0] sh_dout = gnt_reg[0] ? c0_dout_al :
                          gnt_reg[1] ? c1_dout_al : '0;
  wire sh_doe = (gnt_reg[0] && c0_doe) || (gnt_reg[1] && c1_doe);
  wire sh_rd_n = gnt_reg[0] ? c0_rd_n :
                 gnt_reg[1] ? c1_rd_n : 1'b1;
  wire sh_wr_n = gnt_reg[0] ? c0_wr_n :
                 gnt_reg[1] ? c1_wr_n : 1'b1;
  // chip selects are unshared
  wire [1:0] sh_cs_n = {c1_cs_n, c0_cs_n};

  // ---------------- conduit bridge ----------------
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      br_oe_reg <= 1'b0;
      br_doe_reg <= 1'b0;
      br_addr_reg <= '0;
      br_dout_reg <= '0;
      br_rd_n_reg <= 1'b1;
      br_wr_n_reg <= 1'b1;
      br_cs_n_reg <= 2'b11;
      br_din_reg <= '0;
    end else begin
      br_oe_reg <= 1'b1;
      br_doe_reg <= sh_doe;
      br_addr_reg <= sh_addr;
      br_dout_reg <= sh_dout;
      br_rd_n_reg <= sh_rd_n;
      br_wr_n_reg <= sh_wr_n;
      br_cs_n_reg <= sh_cs_n;
      br_din_reg <= pad_data_i;
    end
  end

  assign pad_addr_o = br_addr_reg;
  assign pad_rd_n_o = br_rd_n_reg;
  assign pad_wr_n_o = br_wr_n_reg;
  assign pad_cs_n_o = br_cs_n_reg;
  assign pad_ctl_oe_o = br_oe_reg;
  assign pad_data_o = br_dout_reg;
  assign pad_data_oe_o = br_doe_reg;

  // ---------------- checks ----------------
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);

  sequence s_owner0_leaves;
    gnt_reg[0] ##1 !gnt_reg[0];
  endsequence

  AST_GRANT_ONEHOT: assert property ($onehot0(gnt_reg))
    else $error("more than one controller granted");
  AST_GRANT_KEPT: assert property (
    gnt_reg[0] && c0_req |=> gnt_reg[0])
    else $error("grant lost while controller still busy");
  AST_ROUND_ROBIN: assert property (
    s_owner0_leaves ##0 c1_req |-> ##[0:1] gnt_reg[1])
    else $error("waiting controller not granted in turn");
  AST_ZERO_UPPER: assert property (
    gnt_reg[0] |-> ##1 br_dout_reg[DW-1:`TMB_D0_W] == '0)
    else $error("upper data bits not zero for narrow owner");
  AST_ADDR_UNSHIFTED: assert property (
    gnt_reg[1] |=> br_addr_reg == {{(AW-`TMB_A1_W){1'b0}},
                                   $past(c1_addr)})
    else $error("address altered by the sharer");
  AST_CS_PASS: assert property (
    ##1 pad_cs_n_o == $past({c1_cs_n, c0_cs_n}))
    else $error("chip select not passed through");
  // the edge that releases reset already starts an attempt
  AST_OE_ON: assert property (!$past(rst_i) |-> pad_ctl_oe_o)
    else $error("pad outputs not enabled after reset");
  AST_APB_READY: assert property (
    psel_i && penable_i && !pready_o |=> pready_o)
    else $error("APB answer not given after one wait state");
endmodule
`default_nettype wire
